// >>> rtl/ldc_consts.vh
`ifndef LDC_CONSTS_VH
`define LDC_CONSTS_VH
// register addresses on the configuration port
`define LDC_ADDR_REGULATOR_MODE 4'h4
`define LDC_ADDR_DRIVER_CURRENT_LIMIT 4'h5
`define LDC_ADDR_LINE_CONTROL 4'h6
`define LDC_ADDR_DRIVER_CONFIGURATION 4'h7
// implemented bits per register
`define LDC_MASK_REGULATOR_MODE 8'h0F
`define LDC_MASK_DRIVER_CURRENT_LIMIT 8'hFF
`define LDC_MASK_LINE_CONTROL 8'hCD
`define LDC_MASK_DRIVER_CONFIGURATION 8'hFF
`define LDC_RESET_VALUE 8'h00
// field positions
`define LDC_BIT_SOFT_RESET 7
`define LDC_BIT_DCM 3
`define LDC_BIT_PFM 2
`define LDC_BIT_SPREAD 1
`define LDC_BIT_REG_OFF 0
`define LDC_BIT_LIMIT_OFF 5
`define LDC_BIT_AUTO_REENABLE 0
`define LDC_BIT_LOW_RAIL_OFF 7
`define LDC_BIT_WAKE_OFF 6
`define LDC_BIT_RX_OFF 3
`define LDC_BIT_RX_FILTER 2
`define LDC_BIT_DRIVE_LEVEL 0
`define LDC_BIT_PULLDOWN 5
`define LDC_BIT_PULLUP 4
`define LDC_BIT_LOW_SIDE 3
`define LDC_BIT_PUSH_PULL 2
`define LDC_BIT_POLARITY 1
`define LDC_BIT_DRIVER_EN 0
// regulator modes
`define LDC_REG_MODE_PWM 2'h0
`define LDC_REG_MODE_PFM 2'h1
`define LDC_REG_MODE_DCM 2'h2
// driver topologies
`define LDC_TOPO_PNP 2'h0
`define LDC_TOPO_NPN 2'h1
`define LDC_TOPO_PUSH_PULL 2'h2
// retry off-times in ms and cycles at 125 MHz
`define LDC_CLK_MHZ 125
`define LDC_OFF_TIME_0_MS 50
`define LDC_OFF_TIME_1_MS 100
`define LDC_OFF_TIME_2_MS 200
`define LDC_OFF_TIME_3_MS 500
`define LDC_MS_TO_CYCLES(ms) ((ms) * `LDC_CLK_MHZ * 1000)
`define LDC_SLEW_FORCED_SEL 2'h0
`endif

// >>> rtl/ldc_regfile.v
`timescale 1ns/1ps
`include "ldc_consts.vh"
// the four configuration registers with soft reset
module ldc_regfile (
  input wire i_mclk,
  input wire i_srst,
  input wire i_wr_en,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output reg [7:0] o_regulator_mode,
  output reg [7:0] o_driver_current_limit,
  output reg [7:0] o_line_control,
  output reg [7:0] o_driver_configuration
);
  wire soft_reset;
  // soft reset bit is never stored, it only clears the bank
  assign soft_reset = i_wr_en && (i_addr == `LDC_ADDR_REGULATOR_MODE) &&
                      i_wdata[`LDC_BIT_SOFT_RESET];

  always @(posedge i_mclk) begin
    if (i_srst || soft_reset) begin
      o_regulator_mode <= `LDC_RESET_VALUE;
      o_driver_current_limit <= `LDC_RESET_VALUE;
      o_line_control <= `LDC_RESET_VALUE;
      o_driver_configuration <= `LDC_RESET_VALUE;
    end else if (i_wr_en) begin
      // unused bits masked off so they read zero
      case (i_addr)
        `LDC_ADDR_REGULATOR_MODE: o_regulator_mode <= i_wdata & `LDC_MASK_REGULATOR_MODE;
        `LDC_ADDR_DRIVER_CURRENT_LIMIT: o_driver_current_limit <= i_wdata & `LDC_MASK_DRIVER_CURRENT_LIMIT;
        `LDC_ADDR_LINE_CONTROL: o_line_control <= i_wdata & `LDC_MASK_LINE_CONTROL;
        `LDC_ADDR_DRIVER_CONFIGURATION: o_driver_configuration <= i_wdata & `LDC_MASK_DRIVER_CONFIGURATION;
        default: ;
      endcase
    end
  end

  // registered read mux, unmapped addresses read zero
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else begin
      case (i_addr)
        `LDC_ADDR_REGULATOR_MODE: o_rdata <= o_regulator_mode;
        `LDC_ADDR_DRIVER_CURRENT_LIMIT: o_rdata <= o_driver_current_limit;
        `LDC_ADDR_LINE_CONTROL: o_rdata <= o_line_control;
        `LDC_ADDR_DRIVER_CONFIGURATION: o_rdata <= o_driver_configuration;
        default: o_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// >>> rtl/ldc_retry_timer.v
`timescale 1ns/1ps
`include "ldc_consts.vh"
// fault off-time counter for automatic driver re-enable
module ldc_retry_timer #(
  parameter [31:0] OFF_CYCLES_0 = `LDC_MS_TO_CYCLES(`LDC_OFF_TIME_0_MS),
  parameter [31:0] OFF_CYCLES_1 = `LDC_MS_TO_CYCLES(`LDC_OFF_TIME_1_MS),
  parameter [31:0] OFF_CYCLES_2 = `LDC_MS_TO_CYCLES(`LDC_OFF_TIME_2_MS),
  parameter [31:0] OFF_CYCLES_3 = `LDC_MS_TO_CYCLES(`LDC_OFF_TIME_3_MS)
) (
  input wire i_mclk,
  input wire i_srst,
  input wire i_fault,
  input wire i_auto_reenable,
  input wire [1:0] i_retry_off_time,
  output reg o_fault_off
);
  reg [31:0] count;

  function [31:0] off_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: off_cycles = OFF_CYCLES_0;
        2'h1: off_cycles = OFF_CYCLES_1;
        2'h2: off_cycles = OFF_CYCLES_2;
        default: off_cycles = OFF_CYCLES_3;
      endcase
    end
  endfunction

  // fault latches the driver off; with retry it is released after the off-time
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_fault_off <= 1'b0;
      count <= 32'h0;
    end else if (i_fault) begin
      o_fault_off <= 1'b1;
      count <= off_cycles(i_retry_off_time);
    end else if (o_fault_off && i_auto_reenable) begin
      if (count <= 32'h1) begin
        o_fault_off <= 1'b0;
        count <= 32'h0;
      end else begin
        count <= count - 32'h1;
      end
    end
  end
endmodule

// >>> rtl/ldc_line_driver_cfg.v
`timescale 1ns/1ps
`include "ldc_consts.vh"
// Summary of operation
// - writing 1 to regulator-mode bit 7 resets all registers; bit self-clears
// - DCM bit selects DCM; otherwise PFM bit picks PFM or PWM
// - regulator-mode bit 1 enables spread-spectrum switching
// - regulator-mode bit 0 disables the buck regulator; default enabled
// - current-limit bits 7:6 select 50, 100, 200 or 250 mA
// - limit-disable bit turns limiting off and forces 380 ns slew
// - bits 4:3 select fault blanking 175us, 500us, 1ms or 5ms
// - bits 2:1 select retry off-time 50, 100, 200 or 500 ms
// - with autoretry, fault disables driver for off-time then re-enables
// - control bit 6 disables line wake-up detection
// - control bit 3 disables receive output, making it high impedance
// - control bit 2 enables the 1us receive glitch filter
// - control bit 0 drives the line output level
// - config bits 7:6 select slew; ignored while limiting disabled
// - config bit 5 enables line pull-down current
// - config bit 4 enables line pull-up current
// - push-pull when bit 2 set; else bit 3 picks NPN or PNP
// - config bit 1 sets line polarity: 0 inverted, 1 direct
// - config bit 0 enables the line driver; default disabled
module ldc_line_driver_cfg #(
  parameter [31:0] OFF_CYCLES_0 = `LDC_MS_TO_CYCLES(`LDC_OFF_TIME_0_MS),
  parameter [31:0] OFF_CYCLES_1 = `LDC_MS_TO_CYCLES(`LDC_OFF_TIME_1_MS),
  parameter [31:0] OFF_CYCLES_2 = `LDC_MS_TO_CYCLES(`LDC_OFF_TIME_2_MS),
  parameter [31:0] OFF_CYCLES_3 = `LDC_MS_TO_CYCLES(`LDC_OFF_TIME_3_MS)
) (
  input wire i_mclk,
  input wire i_srst,
  input wire i_wr_en,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_driver_fault,
  output wire [7:0] o_rdata,
  output reg [1:0] o_regulator_mode,
  output reg o_regulator_spread_en,
  output reg o_regulator_off,
  output reg [1:0] o_limit_level,
  output reg o_limit_off,
  output reg [1:0] o_fault_blank_time,
  output reg o_low_rail_regulator_off,
  output reg o_wake_detect_off,
  output reg o_receive_output_off,
  output reg o_receive_glitch_filter_en,
  output reg o_line_drive_level,
  output reg [1:0] o_line_slew_sel,
  output reg o_line_pulldown_en,
  output reg o_line_pullup_en,
  output reg [1:0] o_topology,
  output reg o_line_polarity_sel,
  output reg o_line_driver_en,
  output reg o_driver_fault_off
);
  wire [7:0] regulator_mode;
  wire [7:0] driver_current_limit;
  wire [7:0] line_control;
  wire [7:0] driver_configuration;
  wire fault_off;
  reg [1:0] next_regulator_mode;
  reg [1:0] next_topology;

  ldc_regfile u_regs (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_regulator_mode(regulator_mode),
    .o_driver_current_limit(driver_current_limit),
    .o_line_control(line_control),
    .o_driver_configuration(driver_configuration)
  );

  ldc_retry_timer #(
    .OFF_CYCLES_0(OFF_CYCLES_0),
    .OFF_CYCLES_1(OFF_CYCLES_1),
    .OFF_CYCLES_2(OFF_CYCLES_2),
    .OFF_CYCLES_3(OFF_CYCLES_3)
  ) u_retry (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_fault(i_driver_fault),
    .i_auto_reenable(driver_current_limit[`LDC_BIT_AUTO_REENABLE]),
    .i_retry_off_time(driver_current_limit[2:1]),
    .o_fault_off(fault_off)
  );

  // regulator mode and topology decode
  always @* begin
    if (regulator_mode[`LDC_BIT_DCM])
      next_regulator_mode = `LDC_REG_MODE_DCM;
    else if (regulator_mode[`LDC_BIT_PFM])
      next_regulator_mode = `LDC_REG_MODE_PFM;
    else
      next_regulator_mode = `LDC_REG_MODE_PWM;
    if (driver_configuration[`LDC_BIT_PUSH_PULL])
      next_topology = `LDC_TOPO_PUSH_PULL;
    else if (driver_configuration[`LDC_BIT_LOW_SIDE])
      next_topology = `LDC_TOPO_NPN;
    else
      next_topology = `LDC_TOPO_PNP;
  end

  // control outputs registered so each pin comes from a flop
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_regulator_mode <= `LDC_REG_MODE_PWM;
      o_regulator_spread_en <= 1'b0;
      o_regulator_off <= 1'b0;
      o_limit_level <= 2'h0;
      o_limit_off <= 1'b0;
      o_fault_blank_time <= 2'h0;
      o_low_rail_regulator_off <= 1'b0;
      o_wake_detect_off <= 1'b0;
      o_receive_output_off <= 1'b0;
      o_receive_glitch_filter_en <= 1'b0;
      o_line_drive_level <= 1'b0;
      o_line_slew_sel <= 2'h0;
      o_line_pulldown_en <= 1'b0;
      o_line_pullup_en <= 1'b0;
      o_topology <= `LDC_TOPO_PNP;
      o_line_polarity_sel <= 1'b0;
      o_line_driver_en <= 1'b0;
      o_driver_fault_off <= 1'b0;
    end else begin
      o_regulator_mode <= next_regulator_mode;
      o_regulator_spread_en <= regulator_mode[`LDC_BIT_SPREAD];
      o_regulator_off <= regulator_mode[`LDC_BIT_REG_OFF];
      o_limit_level <= driver_current_limit[7:6];
      o_limit_off <= driver_current_limit[`LDC_BIT_LIMIT_OFF];
      o_fault_blank_time <= driver_current_limit[4:3];
      o_low_rail_regulator_off <= line_control[`LDC_BIT_LOW_RAIL_OFF];
      o_wake_detect_off <= line_control[`LDC_BIT_WAKE_OFF];
      o_receive_output_off <= line_control[`LDC_BIT_RX_OFF];
      o_receive_glitch_filter_en <= line_control[`LDC_BIT_RX_FILTER];
      o_line_drive_level <= line_control[`LDC_BIT_DRIVE_LEVEL];
      // limit-off overrides the programmed slew
      o_line_slew_sel <= driver_current_limit[`LDC_BIT_LIMIT_OFF] ?
                         `LDC_SLEW_FORCED_SEL : driver_configuration[7:6];
      o_line_pulldown_en <= driver_configuration[`LDC_BIT_PULLDOWN];
      o_line_pullup_en <= driver_configuration[`LDC_BIT_PULLUP];
      o_topology <= next_topology;
      o_line_polarity_sel <= driver_configuration[`LDC_BIT_POLARITY];
      // a fault in off-time holds the driver off even if software enabled it
      o_line_driver_en <= driver_configuration[`LDC_BIT_DRIVER_EN] && !fault_off;
      o_driver_fault_off <= fault_off;
    end
  end
endmodule

// >>> sim/ldc_cfg_chk.sv
`timescale 1ns/1ps
// port-level checks on the configuration bank
module ldc_cfg_chk (
  input wire i_mclk,
  input wire i_srst,
  input wire i_wr_en,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_driver_fault,
  input wire [7:0] o_rdata,
  input wire [1:0] o_regulator_mode,
  input wire o_regulator_spread_en,
  input wire [1:0] o_limit_level,
  input wire o_limit_off,
  input wire [1:0] o_line_slew_sel,
  input wire [1:0] o_topology,
  input wire o_line_driver_en,
  input wire o_driver_fault_off
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_dcm_priority: assert property (
    i_wr_en && i_addr == 4'h4 && !i_wdata[7] |-> ##2
    o_regulator_mode == ($past(i_wdata[3], 2) ? 2'h2 : {1'b0, $past(i_wdata[2], 2)})) else $error("mode wrong");
  a_spread_follows: assert property (
    i_wr_en && i_addr == 4'h4 && !i_wdata[7] |-> ##2
    o_regulator_spread_en == $past(i_wdata[1], 2)) else $error("spread wrong");
  a_soft_clear: assert property (
    i_wr_en && i_addr == 4'h4 && i_wdata[7] |-> ##2
    o_regulator_mode == 2'h0 && o_limit_level == 2'h0 && !o_line_driver_en) else $error("soft reset missed");
  a_forced_slew: assert property (
    o_limit_off |-> o_line_slew_sel == 2'h0) else $error("slew not forced");
  a_push_pull_wins: assert property (
    i_wr_en && i_addr == 4'h7 && i_wdata[2] |-> ##2 o_topology == 2'h2) else $error("topology wrong");
  a_unmapped_zero: assert property (
    (i_addr < 4'h4 || i_addr > 4'h7) |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  a_mode_high_zero: assert property (
    i_addr == 4'h4 |=> o_rdata[7:4] == 4'h0) else $error("mode upper bits set");
  a_fault_holds_off: assert property (
    i_driver_fault |-> ##2 o_driver_fault_off) else $error("fault not latched");
  // flag and enable come from the same latch on the same edge
  a_off_kills_drive: assert property (
    o_driver_fault_off |-> !o_line_driver_en) else $error("driver on during fault");
endmodule
bind ldc_line_driver_cfg ldc_cfg_chk chk (.i_mclk(i_mclk), .i_srst(i_srst), .i_wr_en(i_wr_en),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_driver_fault(i_driver_fault), .o_rdata(o_rdata),
  .o_regulator_mode(o_regulator_mode), .o_regulator_spread_en(o_regulator_spread_en),
  .o_limit_level(o_limit_level), .o_limit_off(o_limit_off), .o_line_slew_sel(o_line_slew_sel),
  .o_topology(o_topology), .o_line_driver_en(o_line_driver_en), .o_driver_fault_off(o_driver_fault_off));

// >>> sim/ldc_host_model.sv
`timescale 1ns/1ps
// host side of the register port
module ldc_host_model (
  input wire i_mclk,
  output logic o_wr_en,
  output logic [3:0] o_addr,
  output logic [7:0] o_wdata,
  input wire [7:0] i_rdata
);
  initial begin
    o_wr_en = 1'b0;
    o_addr = 4'h0;
    o_wdata = 8'h00;
  end
  // data flips after the write so a stale value is never mistaken for a hold
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_mclk);
    o_wr_en <= 1'b0;
    o_wdata <= ~d;
    @(posedge i_mclk); // derived outputs land one edge later
    #1;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    @(posedge i_mclk);
    #1 d = i_rdata;
  endtask
endmodule

// >>> sim/ldc_line_driver_cfg_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module ldc_line_driver_cfg_bench;
  localparam int OFF1 = 20;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_driver_fault = 1'b0;
  wire i_wr_en;
  wire [3:0] i_addr;
  wire [7:0] i_wdata, o_rdata;
  wire [1:0] mode, lvl, blank, slew, topo;
  wire spread, roff, loff, lrail, wake, rxoff, filt, q, pd, pu, pol, den, foff;
  int err_count = 0;
  int num_checks = 0;
  int n;
  logic [7:0] v, d;
  always #4 i_mclk = ~i_mclk;
  ldc_host_model host (.i_mclk(i_mclk), .o_wr_en(i_wr_en), .o_addr(i_addr), .o_wdata(i_wdata), .i_rdata(o_rdata));
  // short off-times keep the retry run brief
  ldc_line_driver_cfg #(.OFF_CYCLES_0(32'd10), .OFF_CYCLES_1(32'd20), .OFF_CYCLES_2(32'd30),
    .OFF_CYCLES_3(32'd40)) dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_wr_en(i_wr_en), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_driver_fault(i_driver_fault), .o_rdata(o_rdata), .o_regulator_mode(mode),
    .o_regulator_spread_en(spread), .o_regulator_off(roff), .o_limit_level(lvl), .o_limit_off(loff),
    .o_fault_blank_time(blank), .o_low_rail_regulator_off(lrail), .o_wake_detect_off(wake),
    .o_receive_output_off(rxoff), .o_receive_glitch_filter_en(filt), .o_line_drive_level(q),
    .o_line_slew_sel(slew), .o_line_pulldown_en(pd), .o_line_pullup_en(pu), .o_topology(topo),
    .o_line_polarity_sel(pol), .o_line_driver_en(den), .o_driver_fault_off(foff));
  task rdchk(input logic [3:0] a, input logic [7:0] e);
    host.rd(a, v);
    `CHK("rdata", e, v)
  endtask
  // one-cycle fault; flag and driver drop land together one edge after the latch
  task pulse;
    @(posedge i_mclk);
    i_driver_fault <= 1'b1;
    @(posedge i_mclk);
    i_driver_fault <= 1'b0;
    @(posedge i_mclk);
    #1 `CHK("fault_off", 1'b1, foff)
    `CHK("drv_en", 1'b0, den)
  endtask
  task complete_run;
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_mclk);
    i_srst <= 1'b0;
    for (int a = 4; a < 8; a++) rdchk(a[3:0], 8'h00);
    `CHK("drv_en", 1'b0, den)
    for (int i = 0; i < 4; i++) begin
      host.wr(4'h4, {4'h7, i[1:0], i[0], ~i[0]});
      rdchk(4'h4, {4'h0, i[1:0], i[0], ~i[0]});
      `CHK("mode", (i[1] ? 2'h2 : {1'b0, i[0]}), mode)
      `CHK("spread", i[0], spread)
      `CHK("reg_off", ~i[0], roff)
      host.wr(4'h5, {i[1:0], 1'b0, i[1:0], i[1:0], 1'b0});
      `CHK("limit", i[1:0], lvl)
      `CHK("blank", i[1:0], blank)
      d = {i[1:0], i[0], ~i[0], i[1], i[0], i[0], 1'b1};
      host.wr(4'h7, d);
      rdchk(4'h7, d);
      `CHK("topo", (i[0] ? 2'h2 : {1'b0, i[1]}), topo)
      `CHK("slew", i[1:0], slew)
      `CHK("pulls", {i[0], ~i[0]}, {pd, pu})
      `CHK("polarity", i[0], pol)
      `CHK("drv_en", 1'b1, den)
    end
    host.wr(4'h5, 8'h20);
    `CHK("slew_forced", 3'h4, {loff, slew})
    host.wr(4'h6, 8'hFF);
    rdchk(4'h6, 8'hCD);
    `CHK("control", 5'h1F, {lrail, wake, rxoff, filt, q})
    host.wr(4'h9, 8'hFF);
    rdchk(4'h9, 8'h00);
    rdchk(4'h3, 8'h00);
    host.wr(4'h4, 8'h8F);
    for (int a = 4; a < 8; a++) rdchk(a[3:0], 8'h00);
    `CHK("after_clear", 6'h00, {loff, den, wake, rxoff, mode})
    // retry enabled with the second off-time
    host.wr(4'h5, 8'h03);
    host.wr(4'h7, 8'h01);
    pulse();
    n = 0;
    while (den !== 1'b1 && n < 100) begin
      @(posedge i_mclk);
      #1 n++;
    end
    `CHK("retry_time", 1'b1, (n >= OFF1 - 4 && n <= OFF1 + 4))
    host.wr(4'h5, 8'h02);
    pulse();
    repeat (3 * OFF1) @(posedge i_mclk);
    #1 `CHK("held_off", 2'h1, {den, foff})
    host.wr(4'h4, 8'h80);
    host.wr(4'h7, 8'h01);
    // the fault latch is not a register, so soft reset leaves the driver held off
    `CHK("drv_after_clear", 2'h1, {den, foff})
    complete_run();
  end
  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_mclk);
    err_count++;
    complete_run();
  end
endmodule
